/* File: rtl/swc_config_port.sv */
// Single-wire configuration port with two nine-bit registers
`timescale 1ns/1ns
// Operation
// - Command 02h writes nine bits into the source/gating register.
// - Command A2h reads back the nine source/gating register bits.
// - Exactly nine data bits follow the command, nothing between.
// - Data bits travel least significant bit first both ways.
// - Each falling edge restarts the device slot delay timer.
// - Write slots sample the line once when the timer expires.
// - Read zero: device holds the line low for the delay period.
// - Read one: device leaves the line released.
// - Output-divider register defaults to zero, divide by two.
// - Default: reference output off, sleep pin on, switch pin off.
// - Default post-ratio bypass is zero, post dividers active.
// - Default reference select is zero, internal oscillator.
// - Master reset pulse, then device presence pulse, starts transactions.
// - Eight-bit commands, LSB first, issued after presence.
// - Commands 01h and A1h write and read the divider register.
`include "swc_regs.svh"
module swc_config_port (
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          dq_in,
    output logic               dq_out,
    output logic               dq_oe,
    output swc_pkg::swc_word_t output_divider_config,
    output swc_pkg::swc_word_t source_and_gating_config,
    output logic               prog_mode,
    output logic               commit_pulse
);
    import swc_pkg::*;

    swc_state_e  state_r;
    swc_word_t   div_r;
    swc_word_t   src_r;
    swc_word_t   shift_r;
    logic [7:0]  cmd_r;
    logic [3:0]  bit_cnt_r;
    logic [15:0] pcnt_r;
    logic        strap_done_r;
    logic        prog_r;
    logic        commit_r;
    logic        drive_low_r;
    logic        fall;
    logic        low_long;
    logic        sample_now;
    logic        in_slot;
    logic [7:0]  cmd_nxt;
    swc_word_t   shift_nxt;

    swc_edge_timer u_timer (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .line_in    (dq_in),
        .fall       (fall),
        .low_long   (low_long),
        .sample_now (sample_now),
        .in_slot    (in_slot)
    );

    function automatic logic is_known(input logic [7:0] c);
        return (c == `SWC_CMD_WR_DIV) || (c == `SWC_CMD_RD_DIV) ||
               (c == `SWC_CMD_WR_SRC) || (c == `SWC_CMD_RD_SRC);
    endfunction

    // Ninth data slot of a transfer
    function automatic logic last_data(input logic [3:0] n);
        return n == (`SWC_DATA_BITS - 4'h1);
    endfunction

    // Bits enter at the top so the first one ends up in bit 0
    function automatic swc_word_t shift_in(input logic b, input swc_word_t w);
        return {b, w[8:1]};
    endfunction

    assign cmd_nxt   = {dq_in, cmd_r[7:1]};
    assign shift_nxt = shift_in(dq_in, shift_r);

    // Strap caught on the first clock after reset release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strap_done_r <= 1'b0;
            prog_r       <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            prog_r       <= dq_in;
        end
    end

    // Transaction sequencer: reset pulse, presence, command, data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= SWC_IDLE;
            cmd_r     <= 8'h00;
            shift_r   <= 9'h000;
            bit_cnt_r <= 4'h0;
            pcnt_r    <= 16'h0000;
        end else if (!prog_r) begin
            state_r <= SWC_IDLE;
        end else if (low_long) begin
            // A reset pulse aborts any transfer in flight
            state_r <= SWC_PRES_WAIT;
            pcnt_r  <= 16'h0000;
        end else begin
            case (state_r)
                SWC_IDLE: begin
                end
                SWC_PRES_WAIT: begin
                    // Only high cycles count, so presence follows the end of the pulse
                    if (dq_in) begin
                        pcnt_r <= pcnt_r + 16'h0001;
                        if (pcnt_r == 16'(`SWC_PRES_WAIT_CYC)) begin
                            state_r <= SWC_PRES;
                            pcnt_r  <= 16'h0000;
                        end
                    end
                end
                SWC_PRES: begin
                    pcnt_r <= pcnt_r + 16'h0001;
                    if (pcnt_r == 16'(`SWC_PRES_LEN_CYC)) begin
                        state_r   <= SWC_CMD;
                        bit_cnt_r <= 4'h0;
                    end
                end
                SWC_CMD: begin
                    if (sample_now) begin
                        cmd_r     <= cmd_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `SWC_CMD_BITS - 4'h1) begin
                            bit_cnt_r <= 4'h0;
                            if (!is_known(cmd_nxt)) begin
                                // Unknown code parks the port until the next reset pulse
                                state_r <= SWC_DONE;
                            end else begin
                                case (cmd_nxt)
                                    `SWC_CMD_WR_DIV, `SWC_CMD_WR_SRC: state_r <= SWC_WRITE;
                                    `SWC_CMD_RD_DIV: begin
                                        state_r <= SWC_READ;
                                        shift_r <= div_r;
                                    end
                                    `SWC_CMD_RD_SRC: begin
                                        state_r <= SWC_READ;
                                        shift_r <= src_r;
                                    end
                                    default: state_r <= SWC_DONE;
                                endcase
                            end
                        end
                    end
                end
                SWC_WRITE: begin
                    if (sample_now) begin
                        shift_r   <= shift_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (last_data(bit_cnt_r)) begin
                            state_r <= SWC_DONE;
                        end
                    end
                end
                SWC_READ: begin
                    if (sample_now) begin
                        shift_r   <= {1'b0, shift_r[8:1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (last_data(bit_cnt_r)) begin
                            state_r <= SWC_DONE;
                        end
                    end
                end
                SWC_DONE: begin
                end
                default: state_r <= SWC_IDLE;
            endcase
        end
    end

    // Register storage; commit pulse stands in for non-volatile write
    // A write cut short by a reset pulse never reaches the registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_r    <= `SWC_DIV_RESET;
            src_r    <= `SWC_SRC_RESET;
            commit_r <= 1'b0;
        end else begin
            commit_r <= 1'b0;
            if (prog_r && !low_long && state_r == SWC_WRITE && sample_now &&
                last_data(bit_cnt_r)) begin
                commit_r <= 1'b1;
                if (cmd_r == `SWC_CMD_WR_DIV) begin
                    div_r <= shift_nxt;
                end else begin
                    src_r <= shift_nxt;
                end
            end
        end
    end

    // Pull-down: presence pulse, or a zero bit held for the slot delay
    // Let go on the sample cycle so the wire is high before the next slot
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_low_r <= 1'b0;
        end else if (state_r == SWC_PRES && !low_long) begin
            drive_low_r <= 1'b1;
        end else if (state_r == SWC_READ && (fall || in_slot) && !sample_now) begin
            drive_low_r <= ~shift_r[0];
        end else begin
            drive_low_r <= 1'b0;
        end
    end

    assign dq_out                   = 1'b0;
    assign dq_oe                    = drive_low_r;
    assign output_divider_config    = div_r;
    assign source_and_gating_config = src_r;
    assign prog_mode                = prog_r;
    assign commit_pulse             = commit_r;
endmodule

/* File: rtl/swc_regs.svh */
// Constants for the single-wire configuration port
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
`define SWC_CMD_WR_DIV    8'h01
`define SWC_CMD_RD_DIV    8'hA1
`define SWC_CMD_WR_SRC    8'h02
`define SWC_CMD_RD_SRC    8'hA2
`define SWC_CMD_BITS      4'h8
`define SWC_DATA_BITS     4'h9
`define SWC_DIV_RESET     9'h000
`define SWC_SRC_RESET     9'h034
`define SWC_CLK_NS        8
`define SWC_SAMPLE_NS     30000
`define SWC_RESET_MIN_NS  480000
`define SWC_PRES_WAIT_NS  30000
`define SWC_PRES_LEN_NS   120000
`define SWC_SAMPLE_CYC    (`SWC_SAMPLE_NS / `SWC_CLK_NS)
`define SWC_RESET_CYC     (`SWC_RESET_MIN_NS / `SWC_CLK_NS)
`define SWC_PRES_WAIT_CYC (`SWC_PRES_WAIT_NS / `SWC_CLK_NS)
`define SWC_PRES_LEN_CYC  (`SWC_PRES_LEN_NS / `SWC_CLK_NS)
`endif

/* File: rtl/swc_pkg.sv */
// Types for the single-wire configuration port
package swc_pkg;
    typedef logic [8:0] swc_word_t;
    typedef enum logic [2:0] {
        SWC_IDLE, SWC_PRES_WAIT, SWC_PRES, SWC_CMD, SWC_WRITE, SWC_READ, SWC_DONE
    } swc_state_e;
endpackage

/* File: rtl/swc_edge_timer.sv */
// Falling-edge detector and slot delay timer
`timescale 1ns/1ns
module swc_edge_timer (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        line_in,
    output logic             fall,
    output logic             low_long,
    output logic             sample_now,
    output logic             in_slot
);
    logic        prev_r;
    logic [19:0] low_cnt_r;
    logic [15:0] slot_cnt_r;

    assign fall = prev_r & ~line_in;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= line_in;
        end
    end

    // Measures low time to detect the master reset pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt_r <= 20'h00000;
        end else if (line_in) begin
            low_cnt_r <= 20'h00000;
        end else if (low_cnt_r != 20'hFFFFF) begin
            low_cnt_r <= low_cnt_r + 20'h00001;
        end
    end
    assign low_long = (low_cnt_r == 20'(`SWC_RESET_CYC));

    // Delay timer restarted on every falling edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            slot_cnt_r <= 16'h0000;
        end else if (fall) begin
            slot_cnt_r <= 16'h0001;
        end else if (slot_cnt_r != 16'h0000) begin
            slot_cnt_r <= (slot_cnt_r == 16'(`SWC_SAMPLE_CYC)) ? 16'h0000 : slot_cnt_r + 16'h0001;
        end
    end
    assign in_slot    = (slot_cnt_r != 16'h0000);
    assign sample_now = (slot_cnt_r == 16'(`SWC_SAMPLE_CYC));
endmodule

/* File: verification/swc_config_port_assertions.sv */
// Pin-level checks of the single-wire configuration port
`timescale 1ns/1ns
module swc_config_port_assertions (
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire logic               dq_in,
    input wire logic               dq_out,
    input wire logic               dq_oe,
    input wire swc_pkg::swc_word_t output_divider_config,
    input wire swc_pkg::swc_word_t source_and_gating_config,
    input wire logic               prog_mode,
    input wire logic               commit_pulse
);
    import swc_pkg::*;
    logic        line_q_r;
    logic [15:0] since_fall_r;
    logic [15:0] oe_run_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Cycles since the last falling edge of the wire, saturating
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            line_q_r <= 1'b1;
            since_fall_r <= 16'hFFFF;
            oe_run_r <= 16'h0000;
        end else begin
            line_q_r <= dq_in;
            since_fall_r <= (line_q_r && !dq_in) ? 16'h0000 : since_fall_r + {15'h0000, since_fall_r != 16'hFFFF};
            oe_run_r <= dq_oe ? oe_run_r + 16'h0001 : 16'h0000;
        end
    end
    chk_pull_only: assert property (dq_out == 1'b0) else $error("device drove wire high");
    chk_oe_needs_mode: assert property (!prog_mode |-> !dq_oe) else $error("wire pulled outside mode");
    chk_commit_single: assert property (commit_pulse |=> !commit_pulse) else $error("commit too long");
    chk_regs_commit_only: assert property (!commit_pulse |-> $stable(output_divider_config)
        && $stable(source_and_gating_config)) else $error("register moved without commit");
    chk_zero_hold: assert property ($rose(dq_oe) |-> dq_oe[*8]) else $error("pull-down too short");
    chk_oe_bounded: assert property (oe_run_r < 16'h3B06) else $error("pull-down too long");
    chk_sample_delay: assert property (commit_pulse |-> since_fall_r >= 16'h0E9C
        && since_fall_r <= 16'h0EBA) else $error("sample point off");
    chk_commit_mode: assert property (commit_pulse |-> prog_mode) else $error("commit outside mode");
endmodule
bind swc_config_port swc_config_port_assertions u_chk (.ref_clk(ref_clk), .resetn(resetn), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .output_divider_config(output_divider_config),
    .source_and_gating_config(source_and_gating_config), .prog_mode(prog_mode), .commit_pulse(commit_pulse));

/* File: verification/swc_bus_master.sv */
// Behavioural single-wire bus master
`timescale 1ns/1ns
module swc_bus_master (
    input wire logic ref_clk,
    input wire logic line,
    output logic     pull
);
    initial pull = 1'b0;
    // Holds the wire low outside any transaction, e.g. across a reset
    task automatic park(input logic v);
        pull = v;
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // A one or a read releases early; the read is taken well inside 15 us
    task automatic slot(input logic b, output logic r);
        pull = 1'b1;
        hold(b ? 2 : 4000);
        pull = 1'b0;
        hold(b ? 900 : 1);
        r = line;
        hold(b ? 3300 : 200);
    endtask
    task automatic xact(input logic [7:0] cmd, input logic [8:0] wd, output logic [8:0] rd, output logic seen);
        logic r;
        int   n;
        pull = 1'b1;
        hold(60100);
        pull = 1'b0;
        n = 0;
        seen = 1'b0;
        while (n < 6000 && !seen) begin
            hold(1);
            n++;
            seen = !line;
        end
        n = 0;
        while (n < 20000 && !line) begin
            hold(1);
            n++;
        end
        hold(200);
        for (int i = 0; i < 8; i++) slot(cmd[i], r);
        for (int i = 0; i < 9; i++) begin
            slot(wd[i] | cmd[7], r);
            rd[i] = r;
        end
    endtask
endmodule

/* File: verification/swc_config_port_tb_top.sv */
// Testbench for the single-wire configuration port
`timescale 1ns/1ns
module swc_config_port_tb_top;
    import swc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    wire logic   line;
    wire logic   master_pull;
    logic        dq_out, dq_oe, prog_mode, commit_pulse;
    swc_word_t   div_q, src_q, rd;
    swc_word_t   shadow [2] = '{9'h000, 9'h034};
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    int          commits = 0;
    logic [31:0] lfsr = 32'h8F445496;
    assign line = !(master_pull || (dq_oe && !dq_out));
    always #4 ref_clk = ~ref_clk;
    swc_config_port u_swc_config_port (.ref_clk(ref_clk), .resetn(resetn), .dq_in(line), .dq_out(dq_out),
        .dq_oe(dq_oe), .output_divider_config(div_q), .source_and_gating_config(src_q),
        .prog_mode(prog_mode), .commit_pulse(commit_pulse));
    swc_bus_master u_swc_bus_master (.ref_clk(ref_clk), .line(line), .pull(master_pull));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input swc_word_t got, input swc_word_t exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] cmd, input swc_word_t wd);
        logic ok;
        u_swc_bus_master.xact(cmd, wd, rd, ok);
        check({8'h00, ok}, 9'h001);
        if (cmd[7]) check(rd, shadow[cmd[1]]);
        else shadow[cmd[1]] = wd;
        check(div_q, shadow[0]);
        check(src_q, shadow[1]);
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Sampled away from the launching edge of the registered pulse
    always @(negedge ref_clk) begin
        cycles++;
        if (commit_pulse === 1'b1) commits++;
        if (cycles == 1000000) begin
            fails++;
            $display("ERROR %0t: timeout", $time);
            complete_run();
        end
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        check({8'h00, prog_mode}, 9'h001);
        check(div_q, 9'h000);
        check(src_q, 9'h034);
        run(8'hA1, 9'h000);
        lfsr = lfsr_next(lfsr);
        run(8'h02, lfsr[8:0]);
        run(8'hA2, 9'h000);
        run(8'h01, 9'h1FF);
        run(8'hA1, 9'h000);
        check(9'(commits), 9'h002);
        // Wire held low at reset release must leave the port dormant
        resetn = 1'b0;
        u_swc_bus_master.park(1'b1);
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({7'h00, prog_mode, dq_oe}, 9'h000);
        check(src_q, 9'h034);
        complete_run();
    end
endmodule
